// [hdl/mco_pkg.sv]
package mco_pkg;

  // ------------------------------------------------------------------
  // Register offsets (pointer values)
  // ------------------------------------------------------------------
  localparam logic [7:0] MCO_OFS_CONFIG   = 8'h00;
  localparam logic [7:0] MCO_OFS_STAT_ONE = 8'h01;
  localparam logic [7:0] MCO_OFS_STAT_TWO = 8'h02;
  localparam logic [7:0] MCO_OFS_MASK_ONE = 8'h03;
  localparam logic [7:0] MCO_OFS_MASK_TWO = 8'h04;
  localparam logic [7:0] MCO_OFS_PIN_SEL  = 8'h05;
  localparam logic [7:0] MCO_OFS_OT_CFG   = 8'h06;
  localparam logic [7:0] MCO_OFS_CONV     = 8'h07;
  localparam logic [7:0] MCO_OFS_CH_DIS   = 8'h08;
  localparam logic [7:0] MCO_OFS_RAM_LO   = 8'h20;
  localparam logic [7:0] MCO_OFS_RAM_HI   = 8'h3F;
  localparam logic [7:0] MCO_OFS_RAM_3E   = 8'h3E;
  localparam logic [7:0] MCO_OFS_RAM_3F   = 8'h3F;
  localparam int         MCO_RAM_DEPTH    = 32;

  // ------------------------------------------------------------------
  // Power-on values
  // ------------------------------------------------------------------
  localparam logic [7:0] MCO_RST_CONFIG  = 8'h08;
  localparam logic [7:0] MCO_RST_STAT    = 8'h00;
  localparam logic [7:0] MCO_RST_MASK    = 8'h00;
  localparam logic [7:0] MCO_RST_PIN_SEL = 8'h14;
  localparam logic [7:0] MCO_RST_OT_CFG  = 8'h01;
  localparam logic [7:0] MCO_RST_CONV    = 8'h00;
  localparam logic [7:0] MCO_RST_CH_DIS  = 8'h00;
  localparam logic [7:0] MCO_RST_PTR     = 8'h00;
  localparam logic [7:0] MCO_RST_RAM     = 8'h00;
  localparam logic [7:0] MCO_RST_RAM_3E  = 8'h01;
  localparam logic [7:0] MCO_RST_RAM_3F  = 8'h08;

  // ------------------------------------------------------------------
  // Configuration and pin-select field positions
  // ------------------------------------------------------------------
  localparam int MCO_CFG_START   = 0;
  localparam int MCO_CFG_INT_EN  = 1;
  localparam int MCO_CFG_INT_POL = 2;
  localparam int MCO_CFG_HOLD    = 3;
  localparam int MCO_CFG_RESET   = 4;
  localparam int MCO_CFG_CHASSIS = 5;
  localparam int MCO_CFG_AUX     = 6;
  localparam int MCO_CFG_RESTORE = 7;
  localparam int MCO_SEL_OT_EN   = 6;
  localparam int MCO_SEL_RST_EN  = 7;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam longint MCO_CLK_HZ       = 20000000;
  localparam longint MCO_PULSE_MIN_MS = 10;
  // Least time: round up to whole cycles
  localparam longint MCO_PULSE_CYCLES =
    (MCO_PULSE_MIN_MS * MCO_CLK_HZ + 999) / 1000;
  localparam int     MCO_TREE_WIDTH   = 16;

  // ------------------------------------------------------------------
  // Register port request carrier
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       ptr_wr;
    logic       wr;
    logic       rd;
    logic [7:0] data;
  } mco_req_s;

  // Control fields handed to the measurement sequencer
  typedef struct packed {
    logic [7:0] pin_sel;
    logic [7:0] ot_cfg;
    logic [7:0] conv_rate;
    logic [7:0] chan_dis;
  } mco_ctrl_s;

endpackage : mco_pkg

// [hdl/mco_pulse_timer.sv]
`timescale 1ns/1ps
module mco_pulse_timer
  import mco_pkg::*;
#(
  parameter int CYCLES = 200000
)(
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic start_i,
  input  wire logic abort_i,
  output logic      busy_o
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          busy_r;
  logic          busy_nxt;

  // ------------------------------------------------------------------
  // Count down; a restart while busy stretches the pulse
  // ------------------------------------------------------------------
  always_comb
  begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    if (abort_i)
    begin
      cnt_nxt  = '0;
      busy_nxt = 1'b0;
    end
    else if (start_i)
    begin
      cnt_nxt  = CW'(CYCLES);
      busy_nxt = 1'b1;
    end
    else if (busy_r)
    begin
      cnt_nxt  = cnt_r - CW'(1);
      busy_nxt = (cnt_r != CW'(1));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign busy_o = busy_r;

endmodule : mco_pulse_timer

// [hdl/mco_nand_tree.sv]
`timescale 1ns/1ps
module mco_nand_tree
  import mco_pkg::*;
#(
  parameter int WIDTH = 16
)(
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] pins_i,
  output logic                  result_o
);

  logic [WIDTH:0] chain;
  logic           result_r;

  // ------------------------------------------------------------------
  // Chain of inverting stages: any single pin toggle flips the end
  // ------------------------------------------------------------------
  assign chain[0] = 1'b0;
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_stage
    assign chain[i+1] = chain[i] ^ ~pins_i[i];
  end

  // Registered so the pin comes straight from a flip-flop
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      result_r <= 1'b0;
    else
      result_r <= chain[WIDTH];
  end

  assign result_o = result_r;

endmodule : mco_nand_tree

// [hdl/mco_top.sv]
// Overview of operation
// - Status read returns contents, then clears register
// - Cleared status drops interrupt until next event
// - Hold-clear masks interrupt, freezes status, halts loop
// - Config bit 6 drives aux power pin low
// - Shared pin is reset output when 05h=10
// - Config bit 4 gives timed low reset pulse
// - Test-select low enables tree result on strap
// - Tree output toggles with any included pin
// - Eight-bit pointer selects access, resets to zero
// - Pointer 00h-08h registers, 20h-3Fh RAM
// - Power-on register and RAM values as listed
// - Start bit runs loop; clearing keeps interrupts
// - Interrupt pin asserts only with enable bit
// - Bit 2 picks open-source high or open-drain low
// - Config bit 5 pulls intrusion low timed
// - Bit 7 restores defaults, self clears
// - Mask bit blocks interrupt, status still records
// - Shared pin is overtemp output when 05h=01
`timescale 1ns/1ps
module mco_top
  import mco_pkg::*;
#(
  parameter longint PULSE_CYCLES = MCO_PULSE_CYCLES,
  parameter int     TREE_WIDTH   = MCO_TREE_WIDTH
)(
  input  wire logic                  clk_i,
  input  wire logic                  reset_i,
  input  wire mco_req_s              req_i,
  input  wire logic [15:0]           status_set_i,
  input  wire logic                  overtemp_i,
  input  wire logic                  tree_test_select_i,
  input  wire logic [TREE_WIDTH-1:0] tree_pins_i,
  output logic [7:0]                 rdata_o,
  output logic                       rvalid_o,
  output logic                       monitor_run_o,
  output mco_ctrl_s                  ctrl_o,
  output logic                       int_o,
  output logic                       int_oe_o,
  output logic                       aux_power_drive_o,
  output logic                       aux_power_drive_oe_o,
  output logic                       rst_os_o,
  output logic                       rst_os_oe_o,
  output logic                       intrusion_in_o,
  output logic                       intrusion_in_oe_o,
  output logic                       addr_strap_zero_o,
  output logic                       addr_strap_zero_oe_o
);

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic [7:0] ptr_r,      ptr_nxt;
  logic [7:0] cfg_r,      cfg_nxt;
  logic [7:0] stat1_r,    stat1_nxt;
  logic [7:0] stat2_r,    stat2_nxt;
  logic [7:0] mask1_r,    mask1_nxt;
  logic [7:0] mask2_r,    mask2_nxt;
  logic [7:0] sel_r,      sel_nxt;
  logic [7:0] otc_r,      otc_nxt;
  logic [7:0] conv_r,     conv_nxt;
  logic [7:0] chdis_r,    chdis_nxt;
  logic [7:0] rdata_r,    rdata_nxt;
  logic       rvalid_r,   rvalid_nxt;
  logic [7:0] ram_r   [MCO_RAM_DEPTH];
  logic [7:0] ram_nxt [MCO_RAM_DEPTH];

  logic       cfg_wr;
  logic       restore;
  logic       rst_start;
  logic       chs_start;
  logic       rst_busy;
  logic       chs_busy;
  logic       in_ram;
  logic [4:0] ram_idx;
  logic [7:0] cfg_view;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  assign in_ram    = (ptr_r >= MCO_OFS_RAM_LO) &&
                     (ptr_r <= MCO_OFS_RAM_HI);
  assign ram_idx   = ptr_r[4:0];
  assign cfg_wr    = req_i.wr && !req_i.ptr_wr && (ptr_r == MCO_OFS_CONFIG);
  assign restore   = cfg_wr && req_i.data[MCO_CFG_RESTORE];
  assign rst_start = cfg_wr && !restore &&
                     req_i.data[MCO_CFG_RESET];
  assign chs_start = cfg_wr && !restore &&
                     req_i.data[MCO_CFG_CHASSIS];

  // Self-clearing bits read back the live pulse state; bit 7 reads 0
  always_comb
  begin
    cfg_view                  = cfg_r;
    cfg_view[MCO_CFG_RESET]   = rst_busy;
    cfg_view[MCO_CFG_CHASSIS] = chs_busy;
    cfg_view[MCO_CFG_RESTORE] = 1'b0;
  end

  // ------------------------------------------------------------------
  // Pulse timers for board reset and intrusion clear
  // ------------------------------------------------------------------
  mco_pulse_timer #(
    .CYCLES (int'(PULSE_CYCLES))
  ) u_rst_pulse (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .start_i (rst_start),
    .abort_i (restore),
    .busy_o  (rst_busy)
  );

  mco_pulse_timer #(
    .CYCLES (int'(PULSE_CYCLES))
  ) u_chs_pulse (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .start_i (chs_start),
    .abort_i (restore),
    .busy_o  (chs_busy)
  );

  // ------------------------------------------------------------------
  // Board connectivity tree
  // ------------------------------------------------------------------
  logic tree_result;

  mco_nand_tree #(
    .WIDTH (TREE_WIDTH)
  ) u_tree (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .pins_i   (tree_pins_i),
    .result_o (tree_result)
  );

  // ------------------------------------------------------------------
  // Control registers, pointer and read data
  // ------------------------------------------------------------------
  always_comb
  begin
    ptr_nxt    = ptr_r;
    cfg_nxt    = cfg_r;
    mask1_nxt  = mask1_r;
    mask2_nxt  = mask2_r;
    sel_nxt    = sel_r;
    otc_nxt    = otc_r;
    conv_nxt   = conv_r;
    chdis_nxt  = chdis_r;
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    if (req_i.ptr_wr)
      ptr_nxt = req_i.data;
    else if (req_i.wr)
    begin
      case (ptr_r)
        MCO_OFS_CONFIG:
        begin
          if (restore)
            cfg_nxt = MCO_RST_CONFIG;
          else
            cfg_nxt = req_i.data & 8'h4F;   // Pulse bits live in timers
        end
        MCO_OFS_MASK_ONE: mask1_nxt = req_i.data;
        MCO_OFS_MASK_TWO: mask2_nxt = req_i.data;
        MCO_OFS_PIN_SEL:  sel_nxt   = req_i.data;
        MCO_OFS_OT_CFG:   otc_nxt   = req_i.data;
        MCO_OFS_CONV:     conv_nxt  = req_i.data;
        MCO_OFS_CH_DIS:   chdis_nxt = req_i.data;
        default:          ;         // Status is read-only; RAM below
      endcase
    end
    else if (req_i.rd)
    begin
      rvalid_nxt = 1'b1;
      case (ptr_r)
        MCO_OFS_CONFIG:   rdata_nxt = cfg_view;
        MCO_OFS_STAT_ONE: rdata_nxt = stat1_r;
        MCO_OFS_STAT_TWO: rdata_nxt = stat2_r;
        MCO_OFS_MASK_ONE: rdata_nxt = mask1_r;
        MCO_OFS_MASK_TWO: rdata_nxt = mask2_r;
        MCO_OFS_PIN_SEL:  rdata_nxt = sel_r;
        MCO_OFS_OT_CFG:   rdata_nxt = otc_r;
        MCO_OFS_CONV:     rdata_nxt = conv_r;
        MCO_OFS_CH_DIS:   rdata_nxt = chdis_r;
        default:          rdata_nxt = in_ram ? ram_r[ram_idx] : 8'h00;
      endcase
    end
    // Restore returns the whole control set, not only configuration
    if (restore)
    begin
      mask1_nxt = MCO_RST_MASK;
      mask2_nxt = MCO_RST_MASK;
      sel_nxt   = MCO_RST_PIN_SEL;
      otc_nxt   = MCO_RST_OT_CFG;
      conv_nxt  = MCO_RST_CONV;
      chdis_nxt = MCO_RST_CH_DIS;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ptr_r    <= MCO_RST_PTR;
      cfg_r    <= MCO_RST_CONFIG;
      mask1_r  <= MCO_RST_MASK;
      mask2_r  <= MCO_RST_MASK;
      sel_r    <= MCO_RST_PIN_SEL;
      otc_r    <= MCO_RST_OT_CFG;
      conv_r   <= MCO_RST_CONV;
      chdis_r  <= MCO_RST_CH_DIS;
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else
    begin
      ptr_r    <= ptr_nxt;
      cfg_r    <= cfg_nxt;
      mask1_r  <= mask1_nxt;
      mask2_r  <= mask2_nxt;
      sel_r    <= sel_nxt;
      otc_r    <= otc_nxt;
      conv_r   <= conv_nxt;
      chdis_r  <= chdis_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt status: set wins over read-clear
  // ------------------------------------------------------------------
  logic        run_nxt;
  logic        run_r;
  logic [15:0] sets;
  logic        clr1;
  logic        clr2;

  // Loop halts while held or shut down; held status stays frozen
  assign run_nxt = cfg_nxt[MCO_CFG_START] &&
                   !cfg_nxt[MCO_CFG_HOLD];
  assign sets    = (cfg_r[MCO_CFG_HOLD] || !cfg_r[MCO_CFG_START]) ?
                   16'h0000 : status_set_i;
  assign clr1    = req_i.rd && !req_i.ptr_wr && !req_i.wr &&
                   (ptr_r == MCO_OFS_STAT_ONE);
  assign clr2    = req_i.rd && !req_i.ptr_wr && !req_i.wr &&
                   (ptr_r == MCO_OFS_STAT_TWO);

  always_comb
  begin
    stat1_nxt = (clr1 ? 8'h00 : stat1_r) | sets[7:0];
    stat2_nxt = (clr2 ? 8'h00 : stat2_r) | {2'b00, sets[13:8]};
    if (restore)
    begin
      stat1_nxt = MCO_RST_STAT;
      stat2_nxt = MCO_RST_STAT;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      stat1_r <= MCO_RST_STAT;
      stat2_r <= MCO_RST_STAT;
      run_r   <= 1'b0;
    end
    else
    begin
      stat1_r <= stat1_nxt;
      stat2_r <= stat2_nxt;
      run_r   <= run_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Limit RAM, one flip-flop word per entry
  // ------------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < MCO_RAM_DEPTH; i++)
      ram_nxt[i] = ram_r[i];
    if (req_i.wr && !req_i.ptr_wr && in_ram)
      ram_nxt[ram_idx] = req_i.data;
  end

  for (genvar g = 0; g < MCO_RAM_DEPTH; g++)
  begin : g_ram
    localparam logic [7:0] ADDR = MCO_OFS_RAM_LO + 8'(g);
    localparam logic [7:0] INIT =
      (ADDR == MCO_OFS_RAM_3E) ? MCO_RST_RAM_3E :
      (ADDR == MCO_OFS_RAM_3F) ? MCO_RST_RAM_3F : MCO_RST_RAM;
    always_ff @(posedge clk_i)
    begin
      if (reset_i)
        ram_r[g] <= INIT;
      else
        ram_r[g] <= ram_nxt[g];
    end
  end

  // ------------------------------------------------------------------
  // Pin drivers, all registered
  // ------------------------------------------------------------------
  logic int_act_nxt;
  logic rst_mode;
  logic ot_mode;
  logic tree_mode;
  logic int_o_r,  int_oe_r;
  logic aux_oe_r;
  logic ros_oe_r;
  logic intr_oe_r;
  logic strap_o_r, strap_oe_r;

  // Masked bits still record in status but cannot reach the pin
  assign int_act_nxt = cfg_nxt[MCO_CFG_INT_EN] &&
                       !cfg_nxt[MCO_CFG_HOLD] &&
                       (|(stat1_nxt & ~mask1_nxt) ||
                        |(stat2_nxt & ~mask2_nxt));
  assign rst_mode  = sel_r[MCO_SEL_RST_EN] && !sel_r[MCO_SEL_OT_EN];
  assign ot_mode   = sel_r[MCO_SEL_OT_EN] && !sel_r[MCO_SEL_RST_EN];
  assign tree_mode = !tree_test_select_i;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      int_o_r    <= 1'b0;
      int_oe_r   <= 1'b0;
      aux_oe_r   <= 1'b0;
      ros_oe_r   <= 1'b0;
      intr_oe_r  <= 1'b0;
      strap_o_r  <= 1'b0;
      strap_oe_r <= 1'b0;
    end
    else
    begin
      // High style drives a one, low style sinks to zero
      int_o_r    <= cfg_nxt[MCO_CFG_INT_POL];
      int_oe_r   <= int_act_nxt;
      aux_oe_r   <= cfg_nxt[MCO_CFG_AUX];
      ros_oe_r   <= (rst_mode && rst_busy) ||
                    (ot_mode && overtemp_i);
      intr_oe_r  <= chs_busy;
      strap_o_r  <= tree_result;
      strap_oe_r <= tree_mode;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign rdata_o              = rdata_r;
  assign rvalid_o             = rvalid_r;
  assign monitor_run_o        = run_r;
  assign ctrl_o               = '{pin_sel:   sel_r,
                                  ot_cfg:    otc_r,
                                  conv_rate: conv_r,
                                  chan_dis:  chdis_r};
  assign int_o                = int_o_r;
  assign int_oe_o             = int_oe_r;
  assign aux_power_drive_o    = 1'b0;       // Open drain: only sinks
  assign aux_power_drive_oe_o = aux_oe_r;
  assign rst_os_o             = 1'b0;
  assign rst_os_oe_o          = ros_oe_r;
  assign intrusion_in_o       = 1'b0;
  assign intrusion_in_oe_o    = intr_oe_r;
  assign addr_strap_zero_o    = strap_o_r;
  assign addr_strap_zero_oe_o = strap_oe_r;

endmodule : mco_top

// [verification/mco_top_chk.sv]
`timescale 1ns/1ps
module mco_top_chk
  import mco_pkg::*;
#(
  parameter longint PULSE_CYCLES = MCO_PULSE_CYCLES,
  parameter int     TREE_WIDTH   = MCO_TREE_WIDTH
)(
  input wire logic                  clk_i,
  input wire logic                  reset_i,
  input wire mco_req_s              req_i,
  input wire logic                  tree_test_select_i,
  input wire logic [TREE_WIDTH-1:0] tree_pins_i,
  input wire logic                  rvalid_o,
  input wire mco_ctrl_s             ctrl_o,
  input wire logic                  int_oe_o,
  input wire logic                  aux_power_drive_o,
  input wire logic                  aux_power_drive_oe_o,
  input wire logic                  rst_os_o,
  input wire logic                  rst_os_oe_o,
  input wire logic                  intrusion_in_o,
  input wire logic                  intrusion_in_oe_o,
  input wire logic                  addr_strap_zero_o,
  input wire logic                  addr_strap_zero_oe_o
);
  // ----------------------------------------------------------------
  // Port timing and pin checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // Lone read strobe, the only one that earns an answer
  wire logic rd_go = req_i.rd & ~req_i.wr & ~req_i.ptr_wr;

  property p_rd_answer;
    rd_go |=> rvalid_o;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");
  property p_rvalid_cause;
    rvalid_o |-> $past(rd_go);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("answer without read");
  // Values seen right after reset lets go
  property p_reset_quiet;
    $fell(reset_i) |-> !int_oe_o && !rvalid_o && !rst_os_oe_o &&
      !intrusion_in_oe_o && !aux_power_drive_oe_o &&
      ctrl_o.pin_sel == MCO_RST_PIN_SEL && ctrl_o.ot_cfg == MCO_RST_OT_CFG;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("bad state after reset");
  // Open-drain pins may only pull low
  property p_aux_low;
    aux_power_drive_oe_o |-> !aux_power_drive_o;
  endproperty
  a_aux_low: assert property (p_aux_low)
    else $error("aux pin driven high");
  property p_rst_low;
    rst_os_oe_o |-> !rst_os_o && $past(^ctrl_o.pin_sel[7:6]);
  endproperty
  a_rst_low: assert property (p_rst_low)
    else $error("reset pin driven high");
  property p_intr_low;
    intrusion_in_oe_o |-> !intrusion_in_o;
  endproperty
  a_intr_low: assert property (p_intr_low)
    else $error("intrusion pin driven high");
  property p_strap_oe;
    !$past(reset_i) |-> addr_strap_zero_oe_o == !$past(tree_test_select_i);
  endproperty
  a_strap_oe: assert property (p_strap_oe)
    else $error("strap drive not following test select");
  // One pin flipped in test mode flips the registered result
  property p_tree_toggle;
    !tree_test_select_i && !$past(tree_test_select_i) && !$past(reset_i) &&
      $countones(tree_pins_i ^ $past(tree_pins_i)) == 1
      |=> ##1 $changed(addr_strap_zero_o);
  endproperty
  a_tree_toggle: assert property (p_tree_toggle)
    else $error("tree result did not toggle");

  c_read: cover property (rvalid_o);
  c_rst_pulse: cover property ($rose(rst_os_oe_o));
  c_int: cover property ($rose(int_oe_o));
endmodule : mco_top_chk

// [verification/mco_host.sv]
`timescale 1ns/1ps
module mco_host
  import mco_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output mco_req_s        req_o
);
  initial req_o = '0;

  // Pointer load, then one access; idle data shows the inverted byte
  task automatic access(input logic [7:0] a, input logic w,
                        input logic [7:0] d, output logic [7:0] q,
                        output logic ok);
    @(posedge clk_i);
    req_o <= '{ptr_wr: 1'b1, wr: 1'b0, rd: 1'b0, data: a};
    @(posedge clk_i);
    req_o <= '{ptr_wr: 1'b0, wr: w, rd: !w, data: d};
    @(posedge clk_i);
    req_o <= '{ptr_wr: 1'b0, wr: 1'b0, rd: 1'b0, data: ~d};
    #1;
    for (int i = 0; i < 4 && !w && rvalid_i !== 1'b1; i++)
    begin
      @(posedge clk_i);
      #1;
    end
    q = rdata_i;
    ok = w || rvalid_i === 1'b1;
  endtask : access
endmodule : mco_host

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench
  import mco_pkg::*;
;
  localparam int PC = 20;
  localparam logic [7:0] RA [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
    8'h05, 8'h06, 8'h07, 8'h08, 8'h3E, 8'h3F, 8'h12};
  localparam logic [7:0] RV [12] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h14, 8'h01, 8'h00, 8'h00, 8'h01, 8'h08, 8'h00};
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        ovt = 1'b0;
  logic        sel = 1'b1;
  logic [15:0] set = 16'h0000;
  logic [15:0] pins = 16'hFFFF;
  logic [7:0]  rdata, q, v;
  logic        ok, rvalid, run, io, ioe, ax, axe, ro, roe, co, coe, so, soe;
  mco_req_s    req;
  mco_ctrl_s   ctrl;
  logic [31:0] rng = 32'hE6F1;
  int          n_mismatch = 0;
  int          checks = 0;
  int          cnt;

  mco_top #(.PULSE_CYCLES(PC), .TREE_WIDTH(16)) u_mco_top (
    .clk_i(clk_i), .reset_i(reset_i), .req_i(req), .status_set_i(set),
    .overtemp_i(ovt), .tree_test_select_i(sel), .tree_pins_i(pins),
    .rdata_o(rdata), .rvalid_o(rvalid), .monitor_run_o(run),
    .ctrl_o(ctrl), .int_o(io), .int_oe_o(ioe), .aux_power_drive_o(ax),
    .aux_power_drive_oe_o(axe), .rst_os_o(ro), .rst_os_oe_o(roe),
    .intrusion_in_o(co), .intrusion_in_oe_o(coe),
    .addr_strap_zero_o(so), .addr_strap_zero_oe_o(soe));
  mco_host u_mco_host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .req_o(req));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  // Expected {run, int drive, int level}; hold masks both run and drive
  function automatic logic [7:0] ex(input logic [7:0] c, input logic p);
    return {5'h00, c[0] & ~c[3], p & c[1] & ~c[3], c[2]};
  endfunction : ex
  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    checks++;
    if (act !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t act=%0h exp=%0h", $time, act, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_mco_host.access(a, 1'b1, d, q, ok);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_mco_host.access(a, 1'b0, 8'h00, q, ok);
    chk({7'h00, ok}, 8'h01);
    chk(q, e);
  endtask : rd
  task automatic pulse(input logic [15:0] s);
    @(posedge clk_i);
    set <= s;
    @(posedge clk_i);
    set <= 16'h0000;
  endtask : pulse
  task automatic ck_int(input logic [7:0] c, input logic p);
    wt(2);
    chk({5'h00, run, ioe, io}, ex(c, p));
  endtask : ck_int
  task automatic done(input string s);
    $display("Test %s finished, mismatches so far %0d", s, n_mismatch);
  endtask : done
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (RA[i]) rd(RA[i], RV[i]);
    done("power-on map");
    // Random bytes to registers and RAM; status and holes stay zero
    for (int i = 0; i < 16; i++)
    begin
      rng = xs(rng);
      v = i[0] ? {3'b001, rng[12:8]} : 8'h03 + {5'h00, rng[10:8] % 3'd5};
      wr(v, rng[7:0]);
      rd(v, rng[7:0]);
    end
    wr(8'h01, 8'hFF);
    wr(8'h12, 8'hFF);
    rd(8'h01, 8'h00);
    rd(8'h12, 8'h00);
    wr(8'h03, 8'h00);
    wr(8'h04, 8'h00);
    done("register access");
    // Limits sit in RAM already, so start may be set now
    rng = xs(rng);
    v = rng[7:0] | 8'h01;
    wr(8'h00, 8'h03);
    pulse({8'h00, v});
    ck_int(8'h03, 1'b1);
    wr(8'h00, 8'h02);
    ck_int(8'h02, 1'b1);
    rd(8'h01, v);
    ck_int(8'h02, 1'b0);
    rd(8'h01, 8'h00);
    wr(8'h00, 8'h07);
    pulse({rng[15:8], 8'h00});
    rd(8'h02, {2'b00, rng[13:8]});
    wr(8'h03, 8'hFF);
    pulse({8'h00, v});
    ck_int(8'h07, 1'b0);
    rd(8'h01, v);
    wr(8'h03, 8'h00);
    pulse({8'h00, v});
    ck_int(8'h07, 1'b1);
    wr(8'h00, 8'h0F);
    ck_int(8'h0F, 1'b1);
    pulse({8'h00, ~v});
    wr(8'h00, 8'h07);
    ck_int(8'h07, 1'b1);
    rd(8'h01, v);
    wr(8'h00, 8'h05);
    pulse({8'h00, v});
    ck_int(8'h05, 1'b1);
    rd(8'h01, v);
    done("interrupts");
    wr(8'h00, 8'h40);
    wt(2);
    chk({6'h00, axe, ax}, 8'h02);
    wr(8'h00, 8'h00);
    wt(2);
    chk({6'h00, axe, ax}, 8'h00);
    // Reset pulse then intrusion pulse; count low cycles on each pin
    wr(8'h05, 8'h80);
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h00, k ? 8'h20 : 8'h10);
      cnt = 0;
      for (int j = 0; j < 100; j++)
      begin
        if (k ? coe : roe)
          cnt++;
        else if (cnt > 0)
          break;
        wt(1);
      end
      chk({7'h00, cnt >= PC && cnt <= PC + 2}, 8'h01);
      rd(8'h00, 8'h00);
    end
    wr(8'h05, 8'h40);
    @(posedge clk_i);
    ovt <= 1'b1;
    wt(2);
    chk({7'h00, roe}, 8'h01);
    wr(8'h05, 8'hC0);
    wt(2);
    chk({7'h00, roe}, 8'h00);
    done("pin outputs");
    wr(8'h03, 8'hAA);
    wr(8'h00, 8'h80);
    rd(8'h00, 8'h08);
    rd(8'h03, 8'h00);
    rd(8'h05, 8'h14);
    done("restore");
    @(posedge clk_i);
    sel <= 1'b0;
    wt(3);
    chk({7'h00, soe}, 8'h01);
    for (int i = 0; i < 16; i++)
    begin
      v = {7'h00, so};
      @(posedge clk_i);
      pins[i] <= 1'b0;
      wt(2);
      chk({7'h00, so}, v ^ 8'h01);
      @(posedge clk_i);
      pins[i] <= 1'b1;
      wt(2);
    end
    @(posedge clk_i);
    sel <= 1'b1;
    wt(2);
    chk({7'h00, soe}, 8'h00);
    @(posedge clk_i);
    reset_i <= 1'b1;
    wt(2);
    @(posedge clk_i);
    reset_i <= 1'b0;
    rd(8'h00, 8'h08);
    done("tree and reset");
    end_of_test();
  end
endmodule : testbench

// Checker rides on the top instance
bind mco_top mco_top_chk #(.PULSE_CYCLES(PULSE_CYCLES),
  .TREE_WIDTH(TREE_WIDTH)) u_mco_top_chk (
  .clk_i(clk_i), .reset_i(reset_i), .req_i(req_i),
  .tree_test_select_i(tree_test_select_i), .tree_pins_i(tree_pins_i),
  .rvalid_o(rvalid_o), .ctrl_o(ctrl_o), .int_oe_o(int_oe_o),
  .aux_power_drive_o(aux_power_drive_o),
  .aux_power_drive_oe_o(aux_power_drive_oe_o),
  .rst_os_o(rst_os_o), .rst_os_oe_o(rst_os_oe_o),
  .intrusion_in_o(intrusion_in_o), .intrusion_in_oe_o(intrusion_in_oe_o),
  .addr_strap_zero_o(addr_strap_zero_o),
  .addr_strap_zero_oe_o(addr_strap_zero_oe_o));
